// ===== design/cachan_defines.svh
`ifndef CACHAN_DEFINES_SVH
`define CACHAN_DEFINES_SVH

// Register addresses in the special-function register space.
`define CACHAN_ADDR_FLAG 8'hD9
`define CACHAN_ADDR_MODE 8'hDA
`define CACHAN_ADDR_PWMCFG 8'hF7
`define CACHAN_ADDR_CNT_LO 8'hF9
`define CACHAN_ADDR_CNT_HI 8'hFA
`define CACHAN_ADDR_CP_LO 8'hFB
`define CACHAN_ADDR_CP_HI 8'hFC

// Reset values.
`define CACHAN_RST_BYTE 8'h00
`define CACHAN_RST_WORD 16'h0000
`define CACHAN_RST_MODE 8'h00
`define CACHAN_RST_PWMCFG 8'h00

// Field positions.
`define CACHAN_FLAG_BIT 0
`define CACHAN_MODE_CMP_EN_BIT 6

// Cycle-length field codes.
`define CACHAN_CLEN_8 3'h0
`define CACHAN_CLEN_9 3'h1
`define CACHAN_CLEN_10 3'h2
`define CACHAN_CLEN_11 3'h3

// Counter masks for each cycle length.
`define CACHAN_MASK_8 16'h00FF
`define CACHAN_MASK_9 16'h01FF
`define CACHAN_MASK_10 16'h03FF
`define CACHAN_MASK_11 16'h07FF
`define CACHAN_MASK_16 16'hFFFF

`endif

// ===== design/cachan_pkg.sv
package cachan_pkg;

    // Channel mode control byte, bit 7 down to bit 0.
    typedef struct packed {
        logic wide_pulse_mode;
        logic compare_enable;
        logic rising_edge_capture_enable;
        logic falling_edge_capture_enable;
        logic equality_event_enable;
        logic flip_on_equal_enable;
        logic pwm_enable;
        logic channel_interrupt_mask;
    } cachan_mode_t;

    // Pulse configuration byte; the middle bits are not kept.
    typedef struct packed {
        logic reload_select;
        logic [3:0] unused;
        logic [2:0] cycle_length_field;
    } cachan_pwmcfg_t;

    // One register-port request per clock.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cachan_sfr_req_t;

    typedef enum logic [1:0] {
        OM_IDLE = 2'b00,
        OM_TOGGLE = 2'b01,
        OM_PWM = 2'b10,
        OM_FREQ = 2'b11
    } cachan_omode_t;

endpackage : cachan_pkg

// ===== design/cachan_sync.sv
`timescale 1ns/1ps

module cachan_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Level in and out
    input wire logic din,
    output logic dout
);

    logic stage1_r;
    logic stage2_r;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
        end
        else
        begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;

endmodule : cachan_sync

// ===== design/cachan_match.sv
`timescale 1ns/1ps
`include "cachan_defines.svh"

module cachan_match
(
    // Counter and channel value
    input wire logic [15:0] count,
    input wire logic [15:0] value,
    // Cycle length selection
    input wire logic wide,
    input wire logic [2:0] clen,
    // Comparison results
    output logic eq16,
    output logic eq_lo8,
    output logic below,
    output logic wrap
);

    logic [15:0] mask;

    always_comb
    begin
        if (wide)
        begin
            mask = `CACHAN_MASK_16;
        end
        else
        begin
            case (clen)
                `CACHAN_CLEN_9: mask = `CACHAN_MASK_9;
                `CACHAN_CLEN_10: mask = `CACHAN_MASK_10;
                `CACHAN_CLEN_11: mask = `CACHAN_MASK_11;
                // Reserved codes fall back to the shortest cycle.
                default: mask = `CACHAN_MASK_8;
            endcase
        end
    end

    assign eq16 = (count == value);
    assign eq_lo8 = (count[7:0] == value[7:0]);
    assign below = ((count & mask) < (value & mask));
    assign wrap = ((count & mask) == mask);

endmodule : cachan_match

// ===== design/cachan_channel0.sv
// Behaviour
// - In PWM, wide-pulse bit picks 16-bit cycle, else 8 to 11-bit by field.
// - Mode bit 6 enables comparing the counter with the channel value.
// - Mode bit 5 makes rising pin edges trigger a capture.
// - Mode bit 4 makes falling pin edges trigger a capture.
// - Mode bit 3 sets the event flag when counter equals channel value.
// - Mode bit 2 inverts the pin level when counter equals channel value.
// - Flip-on-equal plus PWM bit selects frequency output mode.
// - Mode bit 1 drives a PWM waveform whose length the wide-pulse bit picks.
// - Mode bit 0 lets the event flag raise an interrupt request.
// - Counter low byte at F9 is read/write and resets to zero.
// - Reading counter high byte at FA returns the snapshot register.
// - Reading the counter low byte loads the snapshot with the upper byte.
// - Channel low byte at FB is read/write and resets to zero.
// - Channel byte addresses may reach the auto-reload value used in 9-11 bit PWM.
// - A write to the channel low byte clears compare enable.
// - Channel high byte at FC is read/write and resets to zero.
// - A write to the channel high byte sets compare enable.
// - Reload-select 0 reaches the channel value, 1 the auto-reload value.
// - Cycle-length codes: 000 8 bits, 001 9 bits, 010 10 bits.
`timescale 1ns/1ps
`include "cachan_defines.svh"

module cachan_channel0
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire cachan_pkg::cachan_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Channel pin
    input wire logic channel0_pin_in,
    output logic channel0_pin_out,
    output logic channel0_pin_oe,
    // Interrupt request
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0] snap_r;
    logic [7:0] snap_nxt;
    logic [15:0] cp_r;
    logic [15:0] cp_nxt;
    logic [15:0] reload_r;
    logic [15:0] reload_nxt;
    cachan_pkg::cachan_mode_t mode_r;
    cachan_pkg::cachan_mode_t mode_nxt;
    cachan_pkg::cachan_pwmcfg_t cfg_r;
    cachan_pkg::cachan_pwmcfg_t cfg_nxt;
    logic flag_r;
    logic flag_nxt;
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic oe_nxt;
    logic irq_r;
    logic irq_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic pin_d_r;
    logic pin_s;
    cachan_pkg::cachan_omode_t omode;
    logic eq16;
    logic eq_lo8;
    logic below;
    logic wrap;
    logic rise;
    logic fall;
    logic cap_evt;
    logic cmp_hit;
    logic wr_cp_lo;
    logic wr_cp_hi;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input and comparison

    cachan_sync u_sync
    (
        .clk(clk),
        .rst(rst),
        .din(channel0_pin_in),
        .dout(pin_s)
    );

    cachan_match u_match
    (
        .count(cnt_r),
        .value(cp_r),
        .wide(mode_r.wide_pulse_mode),
        .clen(cfg_r.cycle_length_field),
        .eq16(eq16),
        .eq_lo8(eq_lo8),
        .below(below),
        .wrap(wrap)
    );

    assign rise = pin_s & ~pin_d_r;
    assign fall = ~pin_s & pin_d_r;
    assign cap_evt = (rise & mode_r.rising_edge_capture_enable)
        | (fall & mode_r.falling_edge_capture_enable);
    assign cmp_hit = mode_r.compare_enable & eq16;
    assign wr_cp_lo = sfr_req.wr & (sfr_req.addr == `CACHAN_ADDR_CP_LO);
    assign wr_cp_hi = sfr_req.wr & (sfr_req.addr == `CACHAN_ADDR_CP_HI);

    always_comb
    begin
        if (mode_r.flip_on_equal_enable && mode_r.pwm_enable)
        begin
            omode = cachan_pkg::OM_FREQ;
        end
        else if (mode_r.pwm_enable)
        begin
            omode = cachan_pkg::OM_PWM;
        end
        else if (mode_r.flip_on_equal_enable)
        begin
            omode = cachan_pkg::OM_TOGGLE;
        end
        else
        begin
            omode = cachan_pkg::OM_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, snapshot and configuration

    always_comb
    begin
        cnt_nxt = cnt_r + 16'h0001;
        snap_nxt = snap_r;
        cfg_nxt = cfg_r;
        // A software write to a counter byte wins over the increment.
        if (sfr_req.wr && sfr_req.addr == `CACHAN_ADDR_CNT_LO)
        begin
            cnt_nxt[7:0] = sfr_req.wdata;
        end
        if (sfr_req.wr && sfr_req.addr == `CACHAN_ADDR_CNT_HI)
        begin
            cnt_nxt[15:8] = sfr_req.wdata;
        end
        if (sfr_req.rd && sfr_req.addr == `CACHAN_ADDR_CNT_LO)
        begin
            snap_nxt = cnt_r[15:8];
        end
        if (sfr_req.wr && sfr_req.addr == `CACHAN_ADDR_PWMCFG)
        begin
            cfg_nxt.reload_select = sfr_req.wdata[7];
            cfg_nxt.unused = 4'h0;
            cfg_nxt.cycle_length_field = sfr_req.wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode, channel value and auto-reload value

    always_comb
    begin
        mode_nxt = mode_r;
        cp_nxt = cp_r;
        reload_nxt = reload_r;
        if (sfr_req.wr && sfr_req.addr == `CACHAN_ADDR_MODE)
        begin
            mode_nxt = sfr_req.wdata;
        end
        if (wr_cp_lo)
        begin
            if (cfg_r.reload_select)
            begin
                reload_nxt[7:0] = sfr_req.wdata;
            end
            else
            begin
                cp_nxt[7:0] = sfr_req.wdata;
            end
            mode_nxt.compare_enable = 1'b0;
        end
        if (wr_cp_hi)
        begin
            if (cfg_r.reload_select)
            begin
                reload_nxt[15:8] = sfr_req.wdata;
            end
            else
            begin
                cp_nxt[15:8] = sfr_req.wdata;
            end
            mode_nxt.compare_enable = 1'b1;
        end
        // Frequency output advances the low byte by the high byte at each hit.
        if (omode == cachan_pkg::OM_FREQ && mode_r.compare_enable && eq_lo8)
        begin
            cp_nxt[7:0] = cp_r[7:0] + cp_r[15:8];
        end
        // Short PWM with any cycle-length code but 000 takes its new duty from the reload value at cycle end.
        if (omode == cachan_pkg::OM_PWM && !mode_r.wide_pulse_mode
            && cfg_r.cycle_length_field != `CACHAN_CLEN_8 && wrap)
        begin
            cp_nxt = reload_r;
        end
        // A capture is the last word on the channel value in its cycle.
        if (cap_evt)
        begin
            cp_nxt = cnt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag, pin, interrupt and read data

    always_comb
    begin
        flag_nxt = flag_r;
        if (sfr_req.wr && sfr_req.addr == `CACHAN_ADDR_FLAG)
        begin
            flag_nxt = sfr_req.wdata[`CACHAN_FLAG_BIT];
        end
        // The hardware set comes last so it beats a clear in the same cycle.
        if (cap_evt)
        begin
            flag_nxt = 1'b1;
        end
        if (cmp_hit && mode_r.equality_event_enable)
        begin
            flag_nxt = 1'b1;
        end

        pin_nxt = pin_r;
        case (omode)
            cachan_pkg::OM_TOGGLE:
            begin
                pin_nxt = cmp_hit ? ~pin_r : pin_r;
            end
            cachan_pkg::OM_FREQ:
            begin
                pin_nxt = (mode_r.compare_enable && eq_lo8) ? ~pin_r : pin_r;
            end
            cachan_pkg::OM_PWM:
            begin
                // Low while the counter is below the duty value, high after.
                pin_nxt = mode_r.compare_enable & ~below;
            end
            default:
            begin
                pin_nxt = pin_r;
            end
        endcase
        oe_nxt = (omode != cachan_pkg::OM_IDLE);
        irq_nxt = flag_r & mode_r.channel_interrupt_mask;

        rdata_nxt = rdata_r;
        if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                `CACHAN_ADDR_FLAG: rdata_nxt = {7'h00, flag_r};
                `CACHAN_ADDR_MODE: rdata_nxt = mode_r;
                `CACHAN_ADDR_PWMCFG: rdata_nxt = cfg_r;
                `CACHAN_ADDR_CNT_LO: rdata_nxt = cnt_r[7:0];
                `CACHAN_ADDR_CNT_HI: rdata_nxt = snap_r;
                `CACHAN_ADDR_CP_LO: rdata_nxt = cfg_r.reload_select ? reload_r[7:0] : cp_r[7:0];
                `CACHAN_ADDR_CP_HI: rdata_nxt = cfg_r.reload_select ? reload_r[15:8] : cp_r[15:8];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= `CACHAN_RST_WORD;
            snap_r <= `CACHAN_RST_BYTE;
            cp_r <= `CACHAN_RST_WORD;
            reload_r <= `CACHAN_RST_WORD;
            mode_r <= `CACHAN_RST_MODE;
            cfg_r <= `CACHAN_RST_PWMCFG;
            flag_r <= 1'b0;
            pin_r <= 1'b0;
            oe_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= `CACHAN_RST_BYTE;
            pin_d_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            snap_r <= snap_nxt;
            cp_r <= cp_nxt;
            reload_r <= reload_nxt;
            mode_r <= mode_nxt;
            cfg_r <= cfg_nxt;
            flag_r <= flag_nxt;
            pin_r <= pin_nxt;
            oe_r <= oe_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
            pin_d_r <= pin_s;
        end
    end

    assign sfr_rdata = rdata_r;
    assign channel0_pin_out = pin_r;
    assign channel0_pin_oe = oe_r;
    assign irq = irq_r;

endmodule : cachan_channel0

// ===== test/cachan_channel0_props.sv
`timescale 1ns/1ps

module cachan_channel0_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire cachan_pkg::cachan_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Channel pin
    input wire logic channel0_pin_in,
    input wire logic channel0_pin_out,
    input wire logic channel0_pin_oe,
    // Interrupt request
    input wire logic irq
);
    logic [7:0] mode_r;
    logic [7:0] mode_nxt;
    logic [7:0] prev_r;

    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs lag a mode write by one register stage, so the last two mode values are kept.
    always_comb
    begin
        mode_nxt = (sfr_req.wr && sfr_req.addr == 8'hDA) ? sfr_req.wdata : mode_r;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= 8'h00;
            prev_r <= 8'h00;
        end
        else
        begin
            mode_r <= mode_nxt;
            prev_r <= mode_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_CNT_LO_RW:
    assert property ((sfr_req.wr && sfr_req.addr == 8'hF9) ##1 (sfr_req.rd && sfr_req.addr == 8'hF9)
        |=> sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("counter low byte readback differs");
    AST_RD_UNMAPPED:
    assert property (sfr_req.rd && sfr_req.addr == 8'h00 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_SNAP_STABLE:
    assert property ((sfr_req.rd && sfr_req.addr == 8'hFA) ##1 (sfr_req.rd && sfr_req.addr == 8'hFA)
        |=> $stable(sfr_rdata))
        else $error("high byte snapshot moved without low read");
    AST_RDATA_HOLD:
    assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    AST_CP_HI_RW:
    assert property ((sfr_req.wr && sfr_req.addr == 8'hFC && mode_r[5:4] == 2'h0 && prev_r[5:4] == 2'h0
        && !mode_r[1]) ##1 (sfr_req.rd && sfr_req.addr == 8'hFC) |=> sfr_rdata == $past(sfr_req.wdata, 2))
        else $error("channel high byte readback differs");
    AST_IRQ_MASKED:
    assert property (!mode_r[0] && !prev_r[0] |-> !irq)
        else $error("interrupt raised while masked");
    AST_FLAG_SET_IRQ:
    assert property (sfr_req.wr && sfr_req.addr == 8'hD9 && sfr_req.wdata[0] && mode_r[0] && prev_r[0]
        |-> ##2 irq)
        else $error("set flag gave no interrupt");
    AST_OE_IDLE:
    assert property (mode_r[2:1] == 2'h0 && prev_r[2:1] == 2'h0 |-> !channel0_pin_oe)
        else $error("pin driven outside output modes");

    COV_IRQ: cover property ($rose(irq));
    COV_TOGGLE: cover property ($rose(channel0_pin_out));
    COV_PWM: cover property (channel0_pin_oe && mode_r[1]);
endmodule : cachan_channel0_props

bind cachan_channel0 cachan_channel0_props props_u (.clk(clk), .rst(rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .channel0_pin_in(channel0_pin_in), .channel0_pin_out(channel0_pin_out),
    .channel0_pin_oe(channel0_pin_oe), .irq(irq));

// ===== test/cachan_pin_model.sv
`timescale 1ns/1ps

module cachan_pin_model
(
    // Level from the far side
    input wire logic drive_level,
    // Block side of the pin
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    // A driven pin reads back its own level, so the far side never fights the block.
    assign pin_in = pin_oe ? pin_out : drive_level;
endmodule : cachan_pin_model

// ===== test/test_counter_array_channel0_regs.sv
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end

module test_counter_array_channel0_regs;
    logic clk;
    logic rst;
    cachan_pkg::cachan_sfr_req_t req;
    logic [7:0] rdata;
    logic pin_in;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic drive;
    logic [7:0] lf;
    logic [7:0] q;
    logic [7:0] h;
    int err_count;
    int check_count;
    int mdl [0:511];
    int t;
    int n;
    int hc;

    cachan_channel0 dut_u (.clk(clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata), .channel0_pin_in(pin_in),
        .channel0_pin_out(pin_out), .channel0_pin_oe(pin_oe), .irq(irq));
    cachan_pin_model pin_u (.drive_level(drive), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Channel bytes live twice in the model; the reload select picks the copy.
    function automatic int key(input logic [7:0] a);
        return ((a == 8'hFB || a == 8'hFC) && mdl[8'hF7][7]) ? a + 256 : a;
    endfunction : key

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{a, 1'b1, 1'b0, d};
        mdl[key(a)] = (a == 8'hF7) ? d & 8'h87 : d;
        if (a == 8'hFB) mdl[8'hDA][6] = 1'b0;
        if (a == 8'hFC) mdl[8'hDA][6] = 1'b1;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        req = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clk);
        q = rdata;
    endtask : rd

    task automatic rchk(input logic [7:0] a);
        rd(a);
        `CHK(q, mdl[key(a)][7:0])
    endtask : rchk

    task automatic idle(input int c);
        req = '0;
        repeat (c) @(negedge clk);
    endtask : idle

    task automatic stop_test();
        if (err_count == 0 && check_count > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        #(40 * 100000);
        err_count++;
        $display("MISMATCH %0t timeout", $time);
        stop_test();
    end

    initial
    begin
        rst = 1'b1;
        req = '0;
        drive = 1'b0;
        lf = 8'h59;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        rchk(8'hFB);
        rchk(8'hFC);
        rchk(8'hDA);
        rd(8'h00);
        `CHK(q, 8'h00)
        lf = lfsr(lf);
        wr(8'hF9, lf);
        rd(8'hF9);
        `CHK(q, lf)
        // Low byte starts near the top so the live high byte moves on before the second read.
        lf = lfsr(lf);
        h = lf;
        wr(8'hF9, 8'h00);
        wr(8'hFA, h);
        wr(8'hF9, 8'hF0);
        rd(8'hF9);
        rd(8'hFA);
        `CHK(q, h)
        idle(20);
        rd(8'hFA);
        rd(8'hFA);
        `CHK(q, h)
        rd(8'hF9);
        rd(8'hFA);
        `CHK(q, h + 8'h01)
        wr(8'hDA, 8'h40);
        wr(8'hFB, lfsr(lf));
        rchk(8'hDA);
        wr(8'hFC, lf);
        rchk(8'hDA);
        wr(8'hF7, 8'hFF);
        rchk(8'hF7);
        wr(8'hFB, 8'h5A);
        wr(8'hFC, 8'hC3);
        rchk(8'hFC);
        rchk(8'hFB);
        wr(8'hF7, 8'h00);
        rchk(8'hFB);
        rchk(8'hFC);
        wr(8'hDA, 8'h21);
        idle(1);
        wr(8'hD9, 8'h01);
        idle(3);
        `CHK(irq, 1'b1)
        wr(8'hD9, 8'h00);
        idle(3);
        `CHK(irq, 1'b0)
        drive = 1'b1;
        idle(8);
        `CHK(irq, 1'b1)
        wr(8'hD9, 8'h00);
        wr(8'hDA, 8'h11);
        drive = 1'b0;
        idle(8);
        `CHK(irq, 1'b1)
        wr(8'hD9, 8'h00);
        drive = 1'b1;
        idle(8);
        `CHK(irq, 1'b0)
        // The pin falls just after the counter is set, so the capture sees it two increments on.
        wr(8'hF9, 8'h00);
        wr(8'hFA, 8'h12);
        drive = 1'b0;
        mdl[8'hFB] = 8'h03;
        mdl[8'hFC] = 8'h12;
        idle(8);
        rchk(8'hFB);
        rchk(8'hFC);
        wr(8'hFA, 8'h00);
        wr(8'hF9, 8'h00);
        wr(8'hFB, 8'h30);
        wr(8'hFC, 8'h00);
        wr(8'hDA, 8'h4D);
        wr(8'hD9, 8'h00);
        idle(4);
        `CHK(pin_oe, 1'b1)
        `CHK(pin_out, 1'b0)
        `CHK(irq, 1'b0)
        idle(50);
        `CHK(pin_out, 1'b1)
        `CHK(irq, 1'b1)
        // The pin flips every high-byte count once running, so 128 samples hold 64 high ones.
        wr(8'hFB, 8'h00);
        wr(8'hFC, 8'h10);
        wr(8'hDA, 8'h46);
        idle(300);
        hc = 0;
        repeat (128)
        begin
            @(negedge clk);
            hc += pin_out;
        end
        `CHK(hc, 64)
        `CHK(pin_oe, 1'b1)
        // Leaving frequency output keeps the low byte from moving while the next values are loaded.
        wr(8'hDA, 8'h00);
        // Case 3 keeps an 11-bit code in the field to show that the wide bit overrides it.
        for (int c = 0; c < 4; c++)
        begin
            n = (c == 3) ? 16 : 8 + c;
            lf = lfsr(lf);
            t = (lf * (c + 1)) % ((1 << n) - 1) + 1;
            wr(8'hF7, {5'h10, c[2:0]});
            wr(8'hFB, t[7:0]);
            wr(8'hFC, t[15:8]);
            wr(8'hF7, {5'h00, c[2:0]});
            wr(8'hFB, t[7:0]);
            wr(8'hFC, t[15:8]);
            wr(8'hDA, (c == 3) ? 8'hC2 : 8'h42);
            idle((c == 3) ? 2 : (1 << n));
            hc = 0;
            repeat (1 << n)
            begin
                @(negedge clk);
                hc += pin_out;
            end
            `CHK(hc, (1 << n) - t)
        end
        stop_test();
    end
endmodule : test_counter_array_channel0_regs
